/* design/autosleep_and_boot_status.sv */
// Auto wake/sleep and boot-complete status logic with boot pulse pins
//
// Overview of operation
// [R1] Mode change sets the transition flag bit 1
// [R2] Idle for inactivity count periods enters sleep
// [R3] Any configured event in sleep returns wake
// [R4] Reading system mode status clears transition flag
// [R5] Feature needs count at least one, enable
// [R6] Boot completion sets boot-done flag bit 0
// [R7] Boot flag holds until reset or hibernate exit
// [R8] Strap low: boot pulse on routed pin
// [R9] Strap low, enabled: one pulse, first time; code pulses again after every soft reset and hibernate exit
// [R10] Strap high: second pin, open-drain low pulse
// [R11] Boot pulse active high after power-on, hibernate
// [R12] Soft reset keeps polarity, drive, routing settings
// [R13] Register access rejected until boot completes
// [R14] Transition coinciding with clearing read stays set
`timescale 1ns/100ps
`default_nettype none
`include "autosleep_params.svh"
module autosleep_and_boot_status
    import autosleep_pkg::*;
#(
    parameter int unsigned BOOT_CYC    = `BOOT_CYC,
    parameter int unsigned PULSE_A_CYC = `PULSE_A_CYC,
    parameter int unsigned PULSE_B_CYC = `PULSE_B_CYC
) (
    // Clock and power-on reset
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    // Other reset events, one-cycle pulses
    input  wire logic       soft_reset_i,
    input  wire logic       hibernate_exit_i,
    // Boot strap pin
    input  wire logic       boot_strap_select_i,
    // Activity sources on this clock
    input  wire logic       config_event_i,
    input  wire logic       odr_tick_i,
    // Register port
    input  wire logic       reg_rd_i,
    input  wire logic       reg_wr_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    output logic            reg_ack_o,
    output logic            reg_err_o,
    // Operating mode
    output logic            sleep_mode_o,
    output logic [`PM_W-1:0] power_setting_o,
    // First event pin
    input  wire logic       event_out_a_i,
    output logic            event_out_a_o,
    output logic            event_out_a_oe_n_o,
    // Second event pin
    input  wire logic       event_out_b_i,
    output logic            event_out_b_o,
    output logic            event_out_b_oe_n_o
);
    localparam logic [`CNT_W-1:0] BOOT_LAST = `CNT_W'(BOOT_CYC - 1);

    // Value taken at power-on, soft reset and hibernate exit
    localparam core_state_type CORE_RST = '{
        boot_st: BT_RUN, boot_cnt: '0, mode: MODE_WAKE,
        last_to_sleep: 1'b0, trans_flag: 1'b0, idle_cnt: `COUNT_ZERO,
        cnt_lo: `BYTE_ZERO, cnt_hi: `BYTE_ZERO, int_en: `INT_EN_RST,
        route: `BYTE_ZERO, cfg2: `BYTE_ZERO, cfg4: `CFG4_RST,
        strap_s1: 1'b0, strap_s2: 1'b0, strap_hi: 1'b0, pulse_req: 1'b0,
        rdata: `BYTE_ZERO, ack: 1'b0, err: 1'b0, pm_out: '0,
        a_out: 1'b0, a_oe_n: 1'b1, b_out: 1'b0, b_oe_n: 1'b1};

    core_state_type q;           // Registered state
    core_state_type d;           // Next state
    logic           booted;      // Boot has completed
    logic [15:0]    limit;       // Programmed inactivity count
    logic           as_en;       // Auto wake/sleep running
    logic           mode_move;   // Mode changes this cycle
    logic           sys_rd;      // Accepted read of system mode status
    logic           any_rst;     // Soft reset or hibernate exit
    logic           pol;         // Active level of the boot pulse
    logic           od;          // Open-drain drive selected
    logic           act;         // Boot pulse running

    pulse_if pif ();             // Link to the pulse timer

    // Pulse timer, started once per boot
    boot_pulse_gen #(
        .PULSE_A_CYC (PULSE_A_CYC),
        .PULSE_B_CYC (PULSE_B_CYC)
    ) u_pulse (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .pif    (pif)
    );

    assign pif.start    = q.pulse_req;
    assign pif.long_sel = q.strap_hi;

    // Next-state logic for boot, registers, auto sleep and pins
    always_comb begin
        d           = q;
        d.ack       = 1'b0;
        d.err       = 1'b0;
        d.pulse_req = 1'b0;
        // Strap pin passes two flops before use
        d.strap_s1  = boot_strap_select_i;
        d.strap_s2  = q.strap_s1;
        booted      = (q.boot_st == BT_DONE);
        limit       = {q.cnt_hi, q.cnt_lo};
        as_en       = booted && (limit != `COUNT_ZERO);  // [R5]
        mode_move   = 1'b0;
        sys_rd      = 1'b0;
        any_rst     = soft_reset_i | hibernate_exit_i;
        pol         = q.cfg4[`POL_BIT];
        od          = q.cfg4[`OD_BIT];
        act         = pif.active;

        // Boot sequencer
        case (q.boot_st)
            BT_RUN: begin
                if (q.boot_cnt == BOOT_LAST) begin
                    d.boot_st   = BT_DONE;  // [R6]
                    // Strap is sampled once, at boot completion
                    d.strap_hi  = q.strap_s2;
                    d.pulse_req = q.strap_s2 | q.int_en[`EN_BOOT_BIT];  // [R9] [R10]
                end else begin
                    d.boot_cnt = q.boot_cnt + 1'b1;
                end
            end
            BT_DONE: d.boot_st = BT_DONE;  // [R7]
            default: d.boot_st = BT_RUN;
        endcase

        // Register port; nothing is accepted before boot completes
        if (reg_rd_i | reg_wr_i) begin
            if (!booted) begin
                d.err = 1'b1;  // [R13]
            end else begin
                d.ack = 1'b1;
                if (reg_rd_i) begin
                    d.rdata = `BYTE_ZERO;
                    case (reg_addr_i)
                        `OFS_EVENT_STATUS: begin
                            d.rdata[`BIT_TRANS]     = q.trans_flag;
                            d.rdata[`BIT_BOOT_DONE] = 1'b1;
                        end
                        `OFS_SYSTEM_MODE_STATUS: begin
                            d.rdata[`BIT_MODE_SLEEP]    = (q.mode == MODE_SLEEP);
                            d.rdata[`BIT_LAST_TO_SLEEP] = q.last_to_sleep;
                            sys_rd = 1'b1;
                        end
                        `OFS_INACT_LOW:     d.rdata = q.cnt_lo;
                        `OFS_INACT_HIGH:    d.rdata = q.cnt_hi;
                        `OFS_EVENT_ENABLE:  d.rdata = q.int_en;
                        `OFS_PIN_ROUTE:     d.rdata = q.route;
                        `OFS_SENS_CFG_TWO:  d.rdata = q.cfg2;
                        `OFS_SENS_CFG_FOUR: d.rdata = q.cfg4;
                        // Unmapped offsets read as zero
                        default: d.rdata = `BYTE_ZERO;
                    endcase
                end
                if (reg_wr_i) begin
                    case (reg_addr_i)
                        `OFS_INACT_LOW:     d.cnt_lo = reg_wdata_i;
                        `OFS_INACT_HIGH:    d.cnt_hi = reg_wdata_i;
                        `OFS_EVENT_ENABLE:  d.int_en = reg_wdata_i;
                        `OFS_PIN_ROUTE:     d.route  = reg_wdata_i;
                        `OFS_SENS_CFG_TWO:  d.cfg2   = reg_wdata_i;
                        `OFS_SENS_CFG_FOUR: d.cfg4   = reg_wdata_i;
                        // Read-only and unmapped offsets ignore writes
                        default: d.cnt_lo = q.cnt_lo;
                    endcase
                end
            end
        end

        // Auto wake/sleep
        if (!as_en) begin
            // Feature off: stay awake, idle count held at zero
            d.idle_cnt = `COUNT_ZERO;
            if (q.mode == MODE_SLEEP) begin
                d.mode    = MODE_WAKE;
                mode_move = 1'b1;
            end
        end else begin
            case (q.mode)
                MODE_WAKE: begin
                    if (config_event_i) begin
                        d.idle_cnt = `COUNT_ZERO;
                    end else if (odr_tick_i) begin
                        if (q.idle_cnt >= limit - 16'h0001) begin
                            d.mode     = MODE_SLEEP;  // [R2]
                            d.idle_cnt = `COUNT_ZERO;
                            mode_move  = 1'b1;
                        end else begin
                            d.idle_cnt = q.idle_cnt + 16'h0001;
                        end
                    end
                end
                MODE_SLEEP: begin
                    if (config_event_i) begin
                        d.mode    = MODE_WAKE;  // [R3]
                        mode_move = 1'b1;
                    end
                end
                default: d.mode = MODE_WAKE;
            endcase
        end
        if (mode_move) begin
            d.last_to_sleep = (d.mode == MODE_SLEEP);
        end

        // Clear first, then set, so a coinciding transition is kept
        if (sys_rd) begin
            d.trans_flag = 1'b0;  // [R4]
        end
        if (mode_move && q.int_en[`EN_INACT_BIT]) begin
            d.trans_flag = 1'b1;  // [R1] [R5] [R14]
        end

        // Power setting follows the mode being entered
        d.pm_out = (d.mode == MODE_SLEEP) ? q.cfg2[`SLEEP_POWER_SETTING_POS +: `PM_W]
                                          : q.cfg2[`WAKE_POWER_SETTING_POS +: `PM_W];

        // Pin drive; both pins float until boot is done
        if (!booted) begin
            d.a_out  = 1'b0;
            d.a_oe_n = 1'b1;
            d.b_out  = 1'b0;
            d.b_oe_n = 1'b1;
        end else if (q.strap_hi) begin
            // Second pin pulls low only, a pull-up is needed outside
            d.a_out  = 1'b0;
            d.a_oe_n = 1'b1;
            d.b_out  = 1'b0;
            d.b_oe_n = !act;  // [R10]
        end else begin
            // Idle at the inactive level; open drain releases a high
            d.a_out  = (act && !q.route[`ROUTE_BOOT_BIT]) ? pol : !pol;  // [R8]
            d.b_out  = (act && q.route[`ROUTE_BOOT_BIT]) ? pol : !pol;  // [R8]
            d.a_oe_n = od & d.a_out;
            d.b_oe_n = od & d.b_out;
        end

        // Soft reset and hibernate exit restart the boot
        if (any_rst) begin
            d          = CORE_RST;
            d.strap_s1 = boot_strap_select_i;
            d.strap_s2 = q.strap_s1;
            d.a_out    = q.a_out;
            d.a_oe_n   = q.a_oe_n;
            d.b_out    = q.b_out;
            d.b_oe_n   = q.b_oe_n;
            // Only hibernate exit returns pin settings to defaults
            if (!hibernate_exit_i) begin
                d.cfg4[`POL_BIT] = q.cfg4[`POL_BIT];  // [R12]
                d.cfg4[`OD_BIT]  = q.cfg4[`OD_BIT];  // [R12]
                d.route          = q.route;  // [R12]
            end
        end
    end

    // State register; reset loads constants only
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= CORE_RST;  // [R11]
        end else begin
            q <= d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata_o        = q.rdata;
    assign reg_ack_o          = q.ack;
    assign reg_err_o          = q.err;
    assign sleep_mode_o       = (q.mode == MODE_SLEEP);
    assign power_setting_o    = q.pm_out;
    assign event_out_a_o      = q.a_out;
    assign event_out_a_oe_n_o = q.a_oe_n;
    assign event_out_b_o      = q.b_out;
    assign event_out_b_oe_n_o = q.b_oe_n;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    AST_TRANS_SETS_FLAG: assert property ( // [R1]
        ($changed(q.mode) && q.int_en[`EN_INACT_BIT]) |-> q.trans_flag)
        else $error("mode change left flag clear");
    AST_SLEEP_AFTER_COUNT: assert property ( // [R2]
        $rose(q.mode == MODE_SLEEP) |-> $past(odr_tick_i) && !$past(config_event_i)
            && ($past(q.idle_cnt) == $past(limit) - 16'h0001))
        else $error("sleep entered before count expired");
    AST_WAKE_ON_EVENT: assert property ( // [R3]
        (q.mode == MODE_SLEEP && config_event_i && !any_rst) |=> q.mode == MODE_WAKE)
        else $error("event did not wake");
    AST_CLEAR_ON_READ: assert property ( // [R4]
        (sys_rd && !mode_move && !any_rst) |=> !q.trans_flag)
        else $error("read did not clear flag");
    AST_NO_SLEEP_DISABLED: assert property ( // [R5]
        (limit == `COUNT_ZERO) |=> q.mode == MODE_WAKE)
        else $error("sleep with zero count");
    AST_BOOT_SET: assert property ( // [R6]
        (q.boot_st == BT_RUN && q.boot_cnt == BOOT_LAST && !any_rst)
            |=> q.boot_st == BT_DONE)
        else $error("boot flag not set on completion");
    AST_BOOT_STICKY: assert property ( // [R7]
        (booted && !any_rst) |=> q.boot_st == BT_DONE)
        else $error("boot flag dropped");
    AST_ROUTE_A: assert property ( // [R8]
        (act && booted && !q.strap_hi && !q.route[`ROUTE_BOOT_BIT] && !any_rst)
            |=> event_out_a_o == $past(pol))
        else $error("boot pulse missing on first pin");
    AST_ONE_PULSE: assert property ( // [R9]
        q.pulse_req |-> $past(q.boot_st) == BT_RUN && booted)
        else $error("pulse requested outside boot completion");
    AST_STRAP_HIGH: assert property ( // [R10]
        (act && booted && q.strap_hi && !any_rst)
            |=> !event_out_b_o && !event_out_b_oe_n_o)
        else $error("open-drain pulse not driven low");
    AST_POL_AFTER_HIB: assert property ( // [R11]
        hibernate_exit_i |=> q.cfg4[`POL_BIT] && (q.boot_st == BT_RUN))
        else $error("polarity not active high after hibernate");
    AST_KEEP_ON_SOFT: assert property ( // [R12]
        (soft_reset_i && !hibernate_exit_i) |=> (q.cfg4[`POL_BIT] == $past(pol))
            && (q.cfg4[`OD_BIT] == $past(od)) && (q.route == $past(q.route)))
        else $error("soft reset lost pin settings");
    AST_REJECT: assert property ( // [R13]
        ((reg_rd_i || reg_wr_i) && !booted) |=> reg_err_o && !reg_ack_o)
        else $error("access accepted before boot");
    AST_SET_WINS: assert property ( // [R14]
        (sys_rd && mode_move && q.int_en[`EN_INACT_BIT] && !any_rst) |=> q.trans_flag)
        else $error("coinciding transition lost");

endmodule // autosleep_and_boot_status
`default_nettype wire

/* shared/autosleep_params.svh */
// Constants for the auto sleep and boot status block
`ifndef AUTOSLEEP_PARAMS_SVH
`define AUTOSLEEP_PARAMS_SVH

// Clock rate in MHz (4 ns period)
`define CLK_MHZ            250
// Boot sequence length in microseconds
`define BOOT_TIME_US       20
// First boot pulse time in microseconds
`define BOOT_PULSE_A_US    60
// Second boot pulse time in milliseconds
`define BOOT_PULSE_B_MS    1
// Derived cycle counts (whole microseconds give whole cycles)
`define BOOT_CYC           (`BOOT_TIME_US * `CLK_MHZ)
`define PULSE_A_CYC        (`BOOT_PULSE_A_US * `CLK_MHZ)
`define PULSE_B_CYC        (`BOOT_PULSE_B_MS * 1000 * `CLK_MHZ)
// Width of the boot and pulse counters
`define CNT_W              24

// Register offsets
`define OFS_EVENT_STATUS   8'h00
`define OFS_SYSTEM_MODE_STATUS       8'h0b
`define OFS_INACT_LOW      8'h0c
`define OFS_INACT_HIGH     8'h0d
`define OFS_EVENT_ENABLE   8'h0e
`define OFS_PIN_ROUTE      8'h0f
`define OFS_SENS_CFG_TWO   8'h10
`define OFS_SENS_CFG_FOUR  8'h11

// Field positions
`define BIT_BOOT_DONE      0
`define BIT_TRANS          1
`define BIT_MODE_SLEEP     0
`define BIT_LAST_TO_SLEEP  1
`define EN_BOOT_BIT        0
`define EN_INACT_BIT       1
`define ROUTE_BOOT_BIT     0
`define POL_BIT            0
`define OD_BIT             1
`define SLEEP_POWER_SETTING_POS       2
`define WAKE_POWER_SETTING_POS        4
`define PM_W               2

// Reset values
`define INT_EN_RST         8'h01
`define CFG4_RST           8'h01
`define BYTE_ZERO          8'h00
`define COUNT_ZERO         16'h0000

`endif

/* shared/autosleep_pkg.sv */
// Types for the auto sleep and boot status block
`include "autosleep_params.svh"
package autosleep_pkg;

    typedef enum logic {MODE_WAKE, MODE_SLEEP} system_mode_status_type;
    typedef enum logic {BT_RUN, BT_DONE} boot_state_type;
    typedef enum logic {PG_IDLE, PG_ACTIVE} pulse_state_type;

    // Whole state of the status core
    typedef struct packed {
        boot_state_type     boot_st;
        logic [`CNT_W-1:0]  boot_cnt;
        system_mode_status_type       mode;
        logic               last_to_sleep;
        logic               trans_flag;
        logic [15:0]        idle_cnt;
        logic [7:0]         cnt_lo;
        logic [7:0]         cnt_hi;
        logic [7:0]         int_en;
        logic [7:0]         route;
        logic [7:0]         cfg2;
        logic [7:0]         cfg4;
        logic               strap_s1;
        logic               strap_s2;
        logic               strap_hi;
        logic               pulse_req;
        logic [7:0]         rdata;
        logic               ack;
        logic               err;
        logic [`PM_W-1:0]   pm_out;
        logic               a_out;
        logic               a_oe_n;
        logic               b_out;
        logic               b_oe_n;
    } core_state_type;

    // Whole state of the pulse timer
    typedef struct packed {
        pulse_state_type    st;
        logic [`CNT_W-1:0]  cnt;
        logic               long_sel;
    } pulse_gen_state_type;

endpackage

/* shared/pulse_if.sv */
// Link between the status core and the boot pulse timer
`timescale 1ns/100ps
`default_nettype none
interface pulse_if;
    logic start;     // One-cycle request for a boot pulse
    logic long_sel;  // High selects the second, longer pulse time
    logic active;    // High while the pulse runs
    modport ctrl (output start, output long_sel, input active);
    modport gen  (input start, input long_sel, output active);
endinterface
`default_nettype wire

/* design/boot_pulse_gen.sv */
// Timer that shapes the single boot pulse
`timescale 1ns/100ps
`default_nettype none
`include "autosleep_params.svh"
module boot_pulse_gen
    import autosleep_pkg::*;
#(
    parameter int unsigned PULSE_A_CYC = `PULSE_A_CYC,
    parameter int unsigned PULSE_B_CYC = `PULSE_B_CYC
) (
    // Clock and reset
    input  wire logic mclk_i,
    input  wire logic rstn_i,
    // Pulse request and status
    pulse_if.gen      pif
);
    localparam logic [`CNT_W-1:0] LAST_A = `CNT_W'(PULSE_A_CYC - 1);
    localparam logic [`CNT_W-1:0] LAST_B = `CNT_W'(PULSE_B_CYC - 1);

    pulse_gen_state_type q;       // Registered state
    pulse_gen_state_type d;       // Next state
    logic [`CNT_W-1:0]   last;    // Final count of the running pulse

    // Pulse length follows the selection latched at start
    always_comb begin
        d    = q;
        last = q.long_sel ? LAST_B : LAST_A;
        case (q.st)
            PG_IDLE: begin
                // A request while busy is ignored, so one pulse per start
                if (pif.start) begin
                    d.st       = PG_ACTIVE;
                    d.cnt      = '0;
                    d.long_sel = pif.long_sel;
                end
            end
            PG_ACTIVE: begin
                if (q.cnt == last) begin
                    d.st = PG_IDLE;  // [R9] [R10]
                end else begin
                    d.cnt = q.cnt + 1'b1;
                end
            end
            default: d.st = PG_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '{st: PG_IDLE, cnt: '0, long_sel: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign pif.active = (q.st == PG_ACTIVE);

    // Pulse ends exactly on its programmed length
    AST_PULSE_LEN: assert property (@(posedge mclk_i) disable iff (!rstn_i) // [R9] [R10]
        $fell(q.st == PG_ACTIVE) |->
            ($past(q.cnt) == ($past(q.long_sel) ? LAST_B : LAST_A)))
        else $error("boot pulse length wrong");

endmodule // boot_pulse_gen
`default_nettype wire

/* bench/host_model.sv */
// Host processor model that drives the register port of the status block
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Clock
    input  wire logic       mclk_i,
    // Register port towards the device
    output logic            reg_rd_o,
    output logic            reg_wr_o,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_ack_i,
    input  wire logic       reg_err_i
);
    // Idle port at time zero
    initial begin
        reg_rd_o    = 1'b0;
        reg_wr_o    = 1'b0;
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // One access: request stands for one cycle up to its taking edge, answer read 1 ns after that edge, once it is withdrawn
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                          output logic [7:0] rdata, output logic err);
        @(posedge mclk_i);
        reg_rd_o    <= ~wr;
        reg_wr_o    <= wr;
        reg_addr_o  <= addr;
        reg_wdata_o <= wdata;
        @(posedge mclk_i);
        reg_rd_o    <= 1'b0;
        reg_wr_o    <= 1'b0;
        reg_addr_o  <= ~addr;  // Idle lines must not look like the last request
        reg_wdata_o <= ~wdata;
        #1;
        rdata = reg_rdata_i;
        err   = reg_err_i | ~reg_ack_i;
    endtask

    // Poll until the device accepts, at most 64 tries; nothing else is sent before then
    task automatic wait_boot(output int tries);
        logic [7:0] d;
        logic       e;
        tries = 0;
        e     = 1'b1;
        while (e && tries < 64) begin
            access(1'b0, 8'h00, 8'h00, d, e);
            tries++;
        end
    endtask
endmodule // host_model
`default_nettype wire

/* bench/tb_autosleep_and_boot_status.sv */
// Self-checking testbench for the auto sleep and boot status block
`timescale 1ns/100ps
`default_nettype none
`include "autosleep_params.svh"
module tb_autosleep_and_boot_status;
    localparam int PB_N = 6;  // Shortened second pulse time
    logic             mclk_i, rstn_i, soft_reset_i, hibernate_exit_i, strap, cfg_ev, odr_tick;
    logic             rd_s, wr_s, ack, err, a_o, a_oe_n, b_o, b_oe_n, sleep_m, clr;
    logic       [7:0] addr, wdata, rdata, d;
    logic [`PM_W-1:0] pm;
    logic             e;
    logic             idle;  // Level a pin rests at outside the boot pulse
    wire logic        a_pin = a_oe_n ? 1'b1 : a_o;  // Pull-ups on both pins
    wire logic        b_pin = b_oe_n ? 1'b1 : b_o;
    int               err_total, checks, seed, cnt, n, ah, al, bh, bl;

    autosleep_and_boot_status #(.BOOT_CYC(8), .PULSE_A_CYC(4), .PULSE_B_CYC(PB_N)) i_dut (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .soft_reset_i(soft_reset_i),
        .hibernate_exit_i(hibernate_exit_i), .boot_strap_select_i(strap),
        .config_event_i(cfg_ev), .odr_tick_i(odr_tick), .reg_rd_i(rd_s), .reg_wr_i(wr_s),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_ack_o(ack),
        .reg_err_o(err), .sleep_mode_o(sleep_m), .power_setting_o(pm),
        .event_out_a_i(a_pin), .event_out_a_o(a_o), .event_out_a_oe_n_o(a_oe_n),
        .event_out_b_i(b_pin), .event_out_b_o(b_o), .event_out_b_oe_n_o(b_oe_n));

    host_model i_host (.mclk_i(mclk_i), .reg_rd_o(rd_s), .reg_wr_o(wr_s), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_ack_i(ack), .reg_err_i(err));

    // Clock
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    // Tally of cycles each pin is driven away from its idle level
    always @(posedge mclk_i) begin
        ah <= clr ? 0 : ah + int'(!a_oe_n && a_o && !idle);
        al <= clr ? 0 : al + int'(!a_oe_n && !a_o && idle);
        bh <= clr ? 0 : bh + int'(!b_oe_n && b_o && !idle);
        bl <= clr ? 0 : bl + int'(!b_oe_n && !b_o && idle);
    end

    task automatic close_out();
        $display("Counts: %0d mismatches, %0d checks", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cmp_tally(input int eah, input int eal, input int ebh, input int ebl);
        cmp_val(8'(ah), 8'(eah), "pin a high cycles");
        cmp_val(8'(al), 8'(eal), "pin a low cycles");
        cmp_val(8'(bh), 8'(ebh), "pin b high cycles");
        cmp_val(8'(bl), 8'(ebl), "pin b low cycles");
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_host.access(1'b1, a, v, d, e);
        cmp_val({7'h00, e}, 8'h00, "write refused");
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        i_host.access(1'b0, a, 8'h00, d, e);
        cmp_val({7'h00, e}, 8'h00, "read refused");
        cmp_val(d, exp, what);
    endtask

    task automatic settle(input int k);
        repeat (k) @(posedge mclk_i);
        #1;
    endtask

    // Output-rate ticks at random spacing, no activity
    task automatic ticks(input int k);
        repeat (k) begin
            @(posedge mclk_i);
            odr_tick <= 1'b1;
            @(posedge mclk_i);
            odr_tick <= 1'b0;
            repeat ($unsigned($random(seed)) % 3) @(posedge mclk_i);
        end
    endtask

    // Restart boot (0 none, 1 soft reset, 2 hibernate exit) and check its pulse
    task automatic boot_chk(input int kind, input int eah, input int eal, input int ebh,
                            input int ebl);
        @(posedge mclk_i);
        clr              <= 1'b1;
        idle             <= (eal + ebl) > 0;  // Low pulses rest high
        soft_reset_i     <= (kind == 1);
        hibernate_exit_i <= (kind == 2);
        @(posedge mclk_i);
        clr              <= 1'b0;
        soft_reset_i     <= 1'b0;
        hibernate_exit_i <= 1'b0;
        i_host.wait_boot(n);
        settle(PB_N + 6);
        cmp_tally(eah, eal, ebh, ebl);
        rd(`OFS_EVENT_STATUS, 8'h01, "boot flag");
    endtask

    // Watchdog sized well above the expected run
    initial begin
        repeat (6000) @(posedge mclk_i);
        err_total++;
        $display("FAIL %0t run did not finish", $time);
        close_out();
    end

    // Main sequence
    initial begin
        seed = 32'hcc52;
        {rstn_i, soft_reset_i, hibernate_exit_i, strap, cfg_ev, odr_tick, clr, idle} = 8'h00;
        {err_total, checks, ah, al, bh, bl} = '0;
        repeat (8) @(posedge mclk_i);
        rstn_i <= 1'b1;
        i_host.access(1'b0, 8'h00, 8'h00, d, e);
        cmp_val({7'h00, e}, 8'h01, "access before boot");
        boot_chk(0, 4, 0, 0, 0);
        rd(8'h3f, 8'h00, "unmapped read");
        cnt = 2 + ($unsigned($random(seed)) % 4);
        wr(`OFS_INACT_LOW, 8'(cnt));
        wr(`OFS_INACT_HIGH, 8'h00);
        wr(`OFS_SENS_CFG_TWO, 8'h24);
        wr(`OFS_EVENT_ENABLE, 8'h03);
        ticks(cnt - 1);
        settle(2);
        cmp_val({7'h00, sleep_m}, 8'h00, "sleep too early");
        ticks(1);
        settle(2);
        cmp_val({7'h00, sleep_m}, 8'h01, "sleep entry");
        cmp_val(8'(pm), 8'h01, "sleep power");
        rd(`OFS_EVENT_STATUS, 8'h03, "flag on sleep");
        rd(`OFS_SYSTEM_MODE_STATUS, 8'h03, "mode after sleep");
        rd(`OFS_EVENT_STATUS, 8'h01, "flag cleared");
        @(posedge mclk_i);
        cfg_ev <= 1'b1;
        @(posedge mclk_i);
        cfg_ev <= 1'b0;
        settle(2);
        cmp_val({7'h00, sleep_m}, 8'h00, "wake on event");
        cmp_val(8'(pm), 8'h02, "wake power");
        rd(`OFS_EVENT_STATUS, 8'h03, "flag on wake");
        rd(`OFS_SYSTEM_MODE_STATUS, 8'h00, "mode after wake");
        wr(`OFS_EVENT_ENABLE, 8'h01);
        ticks(cnt);
        settle(2);
        cmp_val({7'h00, sleep_m}, 8'h01, "sleep with flag off");
        rd(`OFS_EVENT_STATUS, 8'h01, "flag disabled");
        wr(`OFS_INACT_LOW, 8'h00);
        ticks(8);
        settle(2);
        cmp_val({7'h00, sleep_m}, 8'h00, "zero count stays awake");
        wr(`OFS_PIN_ROUTE, 8'h01);
        wr(`OFS_SENS_CFG_FOUR, 8'h02);
        boot_chk(1, 0, 0, 0, 4);
        rd(`OFS_SENS_CFG_FOUR, 8'h02, "drive kept");
        strap <= 1'b1;
        boot_chk(2, 0, 0, 0, PB_N);
        strap <= 1'b0;
        boot_chk(2, 4, 0, 0, 0);
        close_out();
    end
endmodule // tb_autosleep_and_boot_status
`default_nettype wire
